// ==== src/pfs_flash_array.sv ====
// Purpose: 1K x 14 program word store
// Assumes: read data valid the cycle after the read strobe
// Notes:   contents not reset, like real flash
`timescale 1ns/10ps
`default_nettype none
module pfs_flash_array (
  // clock
  input  wire logic  mclk_in,
  // array link
  pfs_flash_if.mem   fl
);
  logic [13:0] mem [0:1023];
  logic [13:0] rdata;
  // registered read port on the read strobe, write on strobe
  always_ff @(posedge mclk_in) begin
    if (fl.wr) begin
      mem[fl.addr] <= fl.wdata;
    end
    if (fl.rd) begin
      rdata <= mem[fl.addr];
    end
  end
  assign fl.rdata = rdata;
endmodule
`default_nettype wire

// ==== src/pfs_flash_if.sv ====
// Purpose: link from the register block to the flash array
// Assumes: single clock
// Notes:   one-cycle read and write strobes
`timescale 1ns/10ps
`default_nettype none
interface pfs_flash_if;
  logic [9:0]  addr;
  logic [13:0] wdata;
  logic [13:0] rdata;
  logic        rd;
  logic        wr;
  modport ctl (output addr, wdata, rd, wr, input rdata);
  modport mem (input addr, wdata, rd, wr, output rdata);
endinterface
`default_nettype wire

// ==== src/pfs_pkg.sv ====
// Purpose: constants for the program flash self access register block
// Assumes: 8-bit register port, 10-bit word address, 14-bit words
// Notes:   offsets are register indices on the plain register port
package pfs_pkg;
  localparam int unsigned AW = 3;
  localparam logic [2:0] OFS_DATA_LOW  = 3'h0;
  localparam logic [2:0] OFS_DATA_HIGH = 3'h1;
  localparam logic [2:0] OFS_ADDR_LOW  = 3'h2;
  localparam logic [2:0] OFS_ADDR_HIGH = 3'h3;
  localparam logic [2:0] OFS_CONTROL   = 3'h4;
  localparam logic [2:0] OFS_UNLOCK    = 3'h5;
  localparam int unsigned BIT_READ     = 0;
  localparam int unsigned BIT_PROGRAM  = 1;
  localparam int unsigned BIT_PERMIT   = 2;
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [5:0] DATA_HIGH_MASK = 6'h3f;
  // read lands two cycles after the command is set
  localparam logic [1:0] READ_DELAY    = 2'h2;
  // program hold, in cycles (arbitrary short model of the write time)
  localparam logic [3:0] PROG_CYCLES   = 4'h8;
endpackage

// ==== src/pfs_regs.sv ====
// Purpose: registers through which the core reads and writes its flash
// Assumes: register port strobes one cycle, read data the next cycle
// Notes:   block write buffering and erase timing are not modelled
//
// Summary of operation
// - data low byte, read and write
// - address low byte, read and write
// - data high holds six upper word bits
// - data high bits 7-6 read zero
// - address high holds two upper address bits
// - address high bits 7-2 read zero
// - program only with permit; permit resets clear
// - command bits set-only, cleared by hardware
// - read lands second cycle after command
`timescale 1ns/10ps
`default_nettype none
module pfs_regs (
  // clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  nrst_in,
  // register port
  input  wire logic [pfs_pkg::AW-1:0] addr_in,
  input  wire logic [7:0]            wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [7:0]            rdata_out,
  // status
  output logic                       busy_out
);
  import pfs_pkg::*;

  typedef enum logic [3:0] {
    PFS_IDLE = 4'b0001,
    PFS_RDWT = 4'b0010,
    PFS_RDLD = 4'b0100,
    PFS_PROG = 4'b1000
  } pfs_state_t;

  pfs_flash_if fl ();
  pfs_flash_array u_array (.mclk_in(mclk_in), .fl(fl));

  logic [7:0] data_low, next_data_low, addr_low, next_addr_low;
  logic [5:0] data_high, next_data_high;
  logic [1:0] addr_high, next_addr_high;
  logic       permit, next_permit, cmd_rd, next_cmd_rd;
  logic       cmd_pg, next_cmd_pg;
  logic [1:0] unlock, next_unlock;
  logic [3:0] cnt, next_cnt;
  logic [7:0] next_rdata;
  logic       next_busy;
  pfs_state_t state, next_state;

  logic wr_ctl;
  assign wr_ctl = wr_in && (addr_in == OFS_CONTROL);

  // register writes, command sequencing and flash strobes
  always_comb begin
    next_data_low  = data_low;
    next_data_high = data_high;
    next_addr_low  = addr_low;
    next_addr_high = addr_high;
    next_permit    = permit;
    next_cmd_rd    = cmd_rd;
    next_cmd_pg    = cmd_pg;
    next_unlock    = unlock;
    next_cnt       = cnt;
    next_state     = state;
    fl.rd          = 1'b0;
    fl.wr          = 1'b0;
    if (wr_in) begin
      case (addr_in)
        OFS_DATA_LOW:  next_data_low = wdata_in;
        OFS_DATA_HIGH: next_data_high = wdata_in[5:0]
                                        & DATA_HIGH_MASK;
        OFS_ADDR_LOW:  next_addr_low = wdata_in;
        OFS_ADDR_HIGH: next_addr_high = wdata_in[1:0];
        default: ;
      endcase
    end
    // unlock tracker: any other write breaks the sequence
    if (wr_in && addr_in == OFS_UNLOCK) begin
      if (wdata_in == UNLOCK_FIRST) begin
        next_unlock = 2'h1;
      end else if (wdata_in == UNLOCK_SECOND && unlock == 2'h1) begin
        next_unlock = 2'h2;
      end else begin
        next_unlock = 2'h0;
      end
    end else if (wr_in && !wr_ctl) begin
      next_unlock = 2'h0;
    end
    if (wr_ctl) begin
      next_permit = wdata_in[BIT_PERMIT];
      next_unlock = 2'h0;
    end
    case (state)
      PFS_IDLE: begin
        // zeros written to command bits do nothing
        if (wr_ctl && wdata_in[BIT_READ]) begin
          next_cmd_rd = 1'b1;
          next_state  = PFS_RDWT;
        end else if (wr_ctl && wdata_in[BIT_PROGRAM] && permit
                     && unlock == 2'h2) begin
          next_cmd_pg = 1'b1;
          next_cnt    = PROG_CYCLES;
          next_state  = PFS_PROG;
        end
      end
      PFS_RDWT: begin
        // first cycle after the command write: array read strobe
        fl.rd      = 1'b1;
        next_state = PFS_RDLD;
      end
      PFS_RDLD: begin
        next_data_low  = fl.rdata[7:0];
        next_data_high = fl.rdata[13:8];
        next_cmd_rd    = 1'b0;
        next_state     = PFS_IDLE;
      end
      PFS_PROG: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          fl.wr       = 1'b1;
          next_cmd_pg = 1'b0;
          next_state  = PFS_IDLE;
        end
      end
      default: next_state = PFS_IDLE;
    endcase
  end

  assign fl.addr  = {addr_high, addr_low};
  assign fl.wdata = {data_high, data_low};

  // read mux, answered one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        OFS_DATA_LOW:  next_rdata = data_low;
        OFS_DATA_HIGH: next_rdata = {2'b00, data_high};
        OFS_ADDR_LOW:  next_rdata = addr_low;
        OFS_ADDR_HIGH: next_rdata = {6'h00, addr_high};
        OFS_CONTROL:   next_rdata = {5'h00, permit, cmd_pg, cmd_rd};
        default:       next_rdata = 8'h00; // unlock port reads zero
      endcase
    end
    next_busy = (next_state != PFS_IDLE);
  end

  // all state registered; synchronous reset clears everything
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      data_low  <= RESET_BYTE;
      data_high <= 6'h00;
      addr_low  <= RESET_BYTE;
      addr_high <= 2'h0;
      permit    <= 1'b0;
      cmd_rd    <= 1'b0;
      cmd_pg    <= 1'b0;
      unlock    <= 2'h0;
      cnt       <= 4'h0;
      state     <= PFS_IDLE;
      rdata_out <= 8'h00;
      busy_out  <= 1'b0;
    end else begin
      data_low  <= next_data_low;
      data_high <= next_data_high;
      addr_low  <= next_addr_low;
      addr_high <= next_addr_high;
      permit    <= next_permit;
      cmd_rd    <= next_cmd_rd;
      cmd_pg    <= next_cmd_pg;
      unlock    <= next_unlock;
      cnt       <= next_cnt;
      state     <= next_state;
      rdata_out <= next_rdata;
      busy_out  <= next_busy;
    end
  end

  sequence s_rd_cmd;
    wr_ctl && wdata_in[BIT_READ] && state == PFS_IDLE;
  endsequence
  sequence s_rd_done;
    cmd_rd ##1 cmd_rd ##1 !cmd_rd;
  endsequence

  chk_hi_read_zero: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    rd_in && addr_in == OFS_DATA_HIGH |=> rdata_out[7:6] == 2'b00)
    else $error("data high upper bits not zero");
  chk_ah_read_zero: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    rd_in && addr_in == OFS_ADDR_HIGH |=> rdata_out[7:2] == 6'h00)
    else $error("address high upper bits not zero");
  chk_read_seq: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_rd_cmd |=> s_rd_done)
    else $error("read command timing wrong");
  chk_read_load: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    state == PFS_RDLD |=> data_low == $past(fl.rdata[7:0]))
    else $error("read data not loaded");
  chk_no_permit: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !permit && state == PFS_IDLE |=> !cmd_pg)
    else $error("program started without permit");
  chk_unlock_need: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    $rose(cmd_pg) |-> $past(unlock) == 2'h2 && $past(permit))
    else $error("program started without unlock");
  chk_cmd_sticky: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    cmd_pg && state == PFS_PROG && cnt > 4'h1 |=> cmd_pg)
    else $error("program bit dropped early");
  chk_prog_ends: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    $rose(cmd_pg) |-> ##[7:9] !cmd_pg)
    else $error("program bit not cleared");
  chk_permit_rst: assert property (
    @(posedge mclk_in)
    !nrst_in |=> !permit)
    else $error("permit not cleared by reset");
endmodule
`default_nettype wire

// ==== tb/pfs_testbench.sv ====
// Purpose: self-checking bench for the flash self access registers
// Assumes: top is pfs_regs, program time of eight cycles
// Notes:   driver queues expected read data, a monitor compares it
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pfs_pkg::*;
  logic          mclk_in  = 1'b0;
  logic          nrst_in  = 1'b0;
  logic [AW-1:0] addr_in  = '0;
  logic [7:0]    wdata_in = 8'h00;
  logic          wr_in    = 1'b0;
  logic          rd_in    = 1'b0;
  logic [7:0]    rdata_out;
  logic          busy_out;
  logic          rd_seen  = 1'b0;
  logic [7:0]    exp_q[$];
  logic [7:0]    seed     = 8'h43;
  logic [7:0]    dl, dh, al, ah;
  int            miscompares = 0;
  int            check_count = 0;
  int            cycles      = 0;

  pfs_regs u_dut (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .addr_in  (addr_in),
    .wdata_in (wdata_in),
    .wr_in    (wr_in),
    .rd_in    (rd_in),
    .rdata_out(rdata_out),
    .busy_out (busy_out)
  );

  // 250 MHz core clock
  always #2 mclk_in = ~mclk_in;

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    // a queued read that never answered is a miss as well
    if (exp_q.size() != 0)
      miscompares++;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // reserved bits read back as zero
  function automatic logic [7:0] rmask(input logic [AW-1:0] a);
    case (a)
      OFS_DATA_LOW, OFS_ADDR_LOW: return 8'hff;
      OFS_DATA_HIGH: return {2'b00, DATA_HIGH_MASK};
      OFS_ADDR_HIGH: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction

  // a gap cycle between accesses keeps each strobe one driver step
  task automatic bus(input logic w, input logic [AW-1:0] a,
                     input logic [7:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= w;
    rd_in    <= ~w;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    bus(1'b0, a, 8'h00);
  endtask

  // busy looked at mid-cycle, first in the cycle right after the strobe
  task automatic see_busy(input logic want);
    #1;
    check({7'h00, busy_out}, {7'h00, want});
    @(posedge mclk_in);
  endtask

  task automatic unlock;
    bus(1'b1, OFS_UNLOCK, UNLOCK_FIRST);
    bus(1'b1, OFS_UNLOCK, UNLOCK_SECOND);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge mclk_in) begin
    if (rd_seen && exp_q.size() > 0)
      check(rdata_out, exp_q.pop_front());
    rd_seen <= rd_in;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge mclk_in);
    nrst_in <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd(a[AW-1:0], RESET_BYTE);
    $display("test reset values done");
    // random bytes, control and unlock left alone
    for (int a = 0; a < 8; a++) begin
      seed = lfsr(seed);
      if (a != 4 && a != 5) begin
        bus(1'b1, a[AW-1:0], seed);
        rd(a[AW-1:0], seed & rmask(a[AW-1:0]));
      end
    end
    $display("test register access done");
    dl = lfsr(seed);
    dh = lfsr(dl);
    al = lfsr(dh);
    ah = lfsr(al);
    bus(1'b1, OFS_CONTROL, 8'h04);
    bus(1'b1, OFS_DATA_LOW, dl);
    bus(1'b1, OFS_DATA_HIGH, dh);
    bus(1'b1, OFS_ADDR_LOW, al);
    bus(1'b1, OFS_ADDR_HIGH, ah);
    unlock();
    bus(1'b1, OFS_CONTROL, 8'h06);
    bus(1'b1, OFS_CONTROL, 8'h04); // zero to a command bit must not stop it
    rd(OFS_CONTROL, 8'h06);
    for (int i = 0; i < 40 && busy_out === 1'b1; i++) @(posedge mclk_in);
    rd(OFS_CONTROL, 8'h04);
    $display("test program done");
    bus(1'b1, OFS_DATA_LOW, 8'h00);
    bus(1'b1, OFS_DATA_HIGH, 8'h00);
    // no unlock, then no permit: both must leave the word alone
    bus(1'b1, OFS_CONTROL, 8'h06);
    see_busy(1'b0);
    bus(1'b1, OFS_CONTROL, 8'h00);
    unlock();
    bus(1'b1, OFS_CONTROL, 8'h02);
    see_busy(1'b0);
    rd(OFS_CONTROL, 8'h00);
    $display("test refused program done");
    bus(1'b1, OFS_CONTROL, 8'h01);
    see_busy(1'b1);
    see_busy(1'b1);
    see_busy(1'b0);
    rd(OFS_DATA_LOW, dl);
    rd(OFS_DATA_HIGH, dh & 8'h3f);
    rd(OFS_CONTROL, 8'h00);
    $display("test read back done");
    repeat (2) @(posedge mclk_in);
    close_out();
  end
endmodule
`default_nettype wire
